// >>> hdl/dcdma_pkg.sv
// package of constants and types for the diskette command dma controller
// ==========================================================================
// Overview of operation
// - command byte write pulls host ready low until the byte is consumed
// - hold request raised before any dma transfer; host grants hold acknowledge
// - while held, host address, data and status drivers are disabled
// - after grant, controller drives its own address, data, status onto bus
// - command string copied into local ram, then hold request dropped
// - write data fetched one byte per hold, taken in t3 only
// - two crc characters computed for the data block and stored locally
// - positioning loads head, then waits for id address mark
// - read track compared with target; mismatch steps head using direction line
// - on track, resync on each id mark until track and sector match
// - write waits 12 byte times, then 5 zeros, mark, 128 data, 2 crc
// - on completion a non-zero status is written to host command string
// - read waits for data address mark, then captures 128 data bytes
// - trailing crc checked; only a verified block is copied to host memory
// - command port address from eight straps, open is one, customary fd
// - non-coincident dma requests are served first come first served, except the read data store, which raises hold even over another request
// - coincident requests resolved by priority chain in to chain out
// - whole-block holds lock out other dma masters; hold is per byte here except during the command string fetch
package dcdma_pkg;
  // ==========================================================================
  // command string layout, offsets from its base in host memory
  localparam logic [2:0] CS_CMD = 3'h0;
  localparam logic [2:0] CS_STATUS = 3'h1;
  localparam logic [2:0] CS_TRACK = 3'h2;
  localparam logic [2:0] CS_SECTOR = 3'h3;
  localparam logic [2:0] CS_BUF_LO = 3'h4;
  localparam logic [2:0] CS_BUF_HI = 3'h5;
  localparam logic [2:0] CS_LEN = 3'h6;
  // ==========================================================================
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h02;
  localparam logic [7:0] BYTE_CMD_EXEC = 8'h00;
  localparam logic [7:0] STATUS_OK = 8'h01;
  localparam logic [7:0] STATUS_CRC_ERR = 8'h02;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h03;
  localparam logic [7:0] PORT_DEFAULT = 8'hfd;
  // ==========================================================================
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [7:0] DATA_MARK = 8'hfb;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] SECTOR_BYTES = 8'h80;
  localparam logic [7:0] GAP_WAIT_BYTES = 8'h0c;
  localparam logic [7:0] SYNC_ZEROS = 8'h05;
  localparam logic [7:0] CRC_BYTES = 8'h02;
  // local ram: command string at base, sector buffer above it
  localparam logic [7:0] RAM_DATA_BASE = 8'h10;
  localparam int RAM_DEPTH = 256;
  // ==========================================================================
  typedef enum logic [15:0] {
    ST_IDLE = 16'h0001,
    ST_CS_FETCH = 16'h0002,
    ST_DECODE = 16'h0004,
    ST_DATA_FETCH = 16'h0008,
    ST_CRC_CALC = 16'h0010,
    ST_SEEK_MARK = 16'h0020,
    ST_ID_CHECK = 16'h0040,
    ST_STEP = 16'h0080,
    ST_GAP_WAIT = 16'h0100,
    ST_WR_FIELD = 16'h0200,
    ST_RD_MARK = 16'h0400,
    ST_RD_FIELD = 16'h0800,
    ST_CRC_CHECK = 16'h1000,
    ST_DATA_STORE = 16'h2000,
    ST_STATUS_PUT = 16'h4000,
    ST_CS_LOAD = 16'h8000
  } dcdma_state_e;
endpackage

// >>> hdl/dcdma_ram.sv
// local ram of the controller with registered read data
`timescale 1ns/100ps
module dcdma_ram
  import dcdma_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [RAM_DEPTH];
  // no reset: contents are don't-care until written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// >>> hdl/dcdma_ctrl.sv
// diskette command dma controller: command port, dma engine, sector sequencer
`timescale 1ns/100ps
module dcdma_ctrl
  import dcdma_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] port_strap,
  input wire logic host_out_strobe,
  input wire logic [7:0] host_io_addr,
  input wire logic [7:0] host_data_in,
  output logic host_ready,
  output logic hold_req,
  input wire logic host_hold_acknowledge,
  input wire logic host_t3,
  output logic host_drv_disable,
  output logic [15:0] dma_addr,
  output logic [7:0] dma_data_out,
  output logic dma_data_oe,
  output logic dma_mem_read,
  output logic dma_mem_write,
  output logic dma_bus_oe,
  input wire logic priority_chain_in,
  output logic priority_chain_out,
  input wire logic other_dma_request,
  output logic head_load,
  output logic step_dir_in,
  output logic step_pulse,
  output logic [7:0] disk_wr_data,
  output logic disk_wr_valid,
  output logic disk_wr_gate,
  input wire logic byte_tick,
  input wire logic id_mark_found,
  input wire logic data_mark_found,
  input wire logic [7:0] disk_rd_data,
  input wire logic disk_rd_valid,
  output logic [7:0] last_status
);
  // ==========================================================================
  // crc helper, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // state
  dcdma_state_e state, next_state;
  logic cmd_pending, next_cmd_pending;
  logic [7:0] port_addr, next_port_addr;
  logic strap_taken, next_strap_taken;
  logic [15:0] cs_base, next_cs_base;
  logic [15:0] buf_base, next_buf_base;
  logic [7:0] cur_track, next_cur_track;
  logic [7:0] tgt_track, next_tgt_track;
  logic [7:0] tgt_sector, next_tgt_sector;
  logic [7:0] cmd_code, next_cmd_code;
  logic [7:0] cnt, next_cnt;
  logic [1:0] sub, next_sub;
  logic [15:0] crc, next_crc;
  logic [7:0] crc_hold, next_crc_hold;
  logic [7:0] status, next_status;
  logic hold_pending, next_hold_pending;
  logic ram_we;
  logic [7:0] ram_addr, ram_wdata, ram_rdata;
  logic bus_granted;

  dcdma_ram u_ram (
    .clk(clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // ours only with grant and chain priority
  assign bus_granted = hold_req & host_hold_acknowledge & priority_chain_in;
  // an asking board blocks lower ones
  assign priority_chain_out = priority_chain_in & ~hold_pending;
  assign hold_req = hold_pending;
  assign host_drv_disable = bus_granted;
  assign dma_bus_oe = bus_granted;
  assign host_ready = ~cmd_pending;
  assign last_status = status;

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic acc;
    logic [7:0] idx;
    acc = 1'b0;
    idx = 8'h00;
    next_state = state;
    next_cmd_pending = cmd_pending;
    next_port_addr = port_addr;
    next_strap_taken = 1'b1;
    next_cs_base = cs_base;
    next_buf_base = buf_base;
    next_cur_track = cur_track;
    next_tgt_track = tgt_track;
    next_tgt_sector = tgt_sector;
    next_cmd_code = cmd_code;
    next_cnt = cnt;
    next_sub = sub;
    next_crc = crc;
    next_crc_hold = crc_hold;
    next_status = status;
    next_hold_pending = 1'b0;
    ram_we = 1'b0;
    ram_addr = 8'h00;
    ram_wdata = 8'h00;
    dma_addr = 16'h0000;
    dma_data_out = 8'h00;
    dma_data_oe = 1'b0;
    dma_mem_read = 1'b0;
    dma_mem_write = 1'b0;
    head_load = 1'b0;
    step_dir_in = 1'b0;
    step_pulse = 1'b0;
    disk_wr_data = 8'h00;
    disk_wr_valid = 1'b0;
    disk_wr_gate = 1'b0;
    if (!strap_taken) begin
      next_port_addr = port_strap;
    end
    // byte taken only in t3
    acc = bus_granted & host_t3;
    case (state)
      ST_IDLE: begin
        if (host_out_strobe && host_io_addr == port_addr && !cmd_pending) begin
          next_cmd_pending = 1'b1;
          next_cmd_code = host_data_in;
        end
        if (cmd_pending) begin
          next_cmd_pending = 1'b0;
          if (cmd_code == BYTE_CMD_EXEC) begin
            next_cnt = 8'h00;
            next_state = ST_CS_FETCH;
          end
        end
      end
      ST_CS_FETCH: begin
        next_hold_pending = !other_dma_request || hold_req;
        dma_addr = cs_base + {13'h0000, cnt[2:0]};
        if (acc) begin
          dma_mem_read = 1'b1;
          ram_we = 1'b1;
          ram_addr = cnt;
          ram_wdata = host_data_in;
          next_cnt = cnt + 8'h01;
          if (cnt[2:0] == CS_TRACK) next_tgt_track = host_data_in;
          if (cnt[2:0] == CS_SECTOR) next_tgt_sector = host_data_in;
          if (cnt[2:0] == CS_BUF_LO) next_buf_base[7:0] = host_data_in;
          if (cnt[2:0] == CS_BUF_HI) next_buf_base[15:8] = host_data_in;
          if (cnt[2:0] == CS_CMD) next_cmd_code = host_data_in;
          if (cnt[2:0] == CS_LEN - 3'h1) begin
            next_hold_pending = 1'b0;
            next_state = ST_DECODE;
          end
        end
      end
      ST_DECODE: begin
        next_cnt = 8'h00;
        next_crc = CRC_PRESET;
        if (cmd_code == CMD_WRITE) begin
          next_state = ST_DATA_FETCH;
        end else if (cmd_code == CMD_READ) begin
          next_state = ST_SEEK_MARK;
        end else begin
          next_status = STATUS_BAD_CMD;
          next_state = ST_STATUS_PUT;
        end
      end
      ST_DATA_FETCH: begin
        // one byte per hold, released between bytes to spare other masters
        next_hold_pending = hold_req || !other_dma_request;
        dma_addr = buf_base + {8'h00, cnt};
        if (acc) begin
          dma_mem_read = 1'b1;
          ram_we = 1'b1;
          ram_addr = RAM_DATA_BASE + cnt;
          ram_wdata = host_data_in;
          next_crc = crc_byte(cnt == 8'h00 ? crc_byte(crc, DATA_MARK) : crc, host_data_in);
          next_cnt = cnt + 8'h01;
          next_hold_pending = 1'b0;
          if (cnt == SECTOR_BYTES - 8'h01) next_state = ST_CRC_CALC;
        end
      end
      ST_CRC_CALC: begin
        // crc kept beside the data, low byte in the last slot
        ram_we = 1'b1;
        ram_addr = RAM_DATA_BASE + SECTOR_BYTES + {7'h00, sub[0]};
        ram_wdata = sub[0] ? crc[7:0] : crc[15:8];
        next_sub = sub + 2'h1;
        if (sub[0]) begin
          next_sub = 2'h0;
          next_state = ST_SEEK_MARK;
        end
      end
      ST_SEEK_MARK: begin
        head_load = 1'b1;
        next_cnt = 8'h00;
        if (id_mark_found) next_state = ST_ID_CHECK;
      end
      ST_ID_CHECK: begin
        head_load = 1'b1;
        if (disk_rd_valid) begin
          next_cnt = cnt + 8'h01;
          if (cnt == 8'h00) begin
            next_cur_track = disk_rd_data;
            if (disk_rd_data != tgt_track) next_state = ST_STEP;
          end else begin
            next_cnt = 8'h00;
            if (disk_rd_data == tgt_sector) begin
              next_state = cmd_code == CMD_WRITE ? ST_GAP_WAIT : ST_RD_MARK;
            end else begin
              next_state = ST_SEEK_MARK;
            end
          end
        end
      end
      ST_STEP: begin
        head_load = 1'b1;
        step_dir_in = tgt_track > cur_track;
        step_pulse = 1'b1;
        next_cur_track = step_dir_in ? cur_track + 8'h01 : cur_track - 8'h01;
        next_state = ST_SEEK_MARK;
      end
      ST_GAP_WAIT: begin
        head_load = 1'b1;
        if (byte_tick) begin
          next_cnt = cnt + 8'h01;
          if (cnt == GAP_WAIT_BYTES - 8'h01) begin
            next_cnt = 8'h00;
            next_state = ST_WR_FIELD;
          end
        end
      end
      ST_WR_FIELD: begin
        // ram read runs one cycle ahead
        head_load = 1'b1;
        disk_wr_gate = 1'b1;
        idx = cnt - SYNC_ZEROS - 8'h01;
        ram_addr = RAM_DATA_BASE + idx;
        if (cnt < SYNC_ZEROS) begin
          disk_wr_data = ZERO_BYTE;
        end else if (cnt == SYNC_ZEROS) begin
          disk_wr_data = DATA_MARK;
        end else begin
          disk_wr_data = ram_rdata;
        end
        if (byte_tick) begin
          disk_wr_valid = 1'b1;
          next_cnt = cnt + 8'h01;
          ram_addr = RAM_DATA_BASE + idx + 8'h01;
          if (cnt == SYNC_ZEROS + SECTOR_BYTES + CRC_BYTES) begin
            next_status = STATUS_OK;
            next_state = ST_STATUS_PUT;
          end
        end
      end
      ST_RD_MARK: begin
        head_load = 1'b1;
        next_crc = crc_byte(CRC_PRESET, DATA_MARK);
        next_cnt = 8'h00;
        if (data_mark_found) next_state = ST_RD_FIELD;
      end
      ST_RD_FIELD: begin
        head_load = 1'b1;
        if (disk_rd_valid) begin
          next_crc = crc_byte(crc, disk_rd_data);
          ram_we = cnt < SECTOR_BYTES;
          ram_addr = RAM_DATA_BASE + cnt;
          ram_wdata = disk_rd_data;
          next_cnt = cnt + 8'h01;
          if (cnt == SECTOR_BYTES + CRC_BYTES - 8'h01) next_state = ST_CRC_CHECK;
        end
      end
      ST_CRC_CHECK: begin
        // residue over data plus crc is zero when intact
        next_cnt = 8'h00;
        if (crc == 16'h0000) begin
          next_state = ST_DATA_STORE;
        end else begin
          next_status = STATUS_CRC_ERR;
          next_state = ST_STATUS_PUT;
        end
      end
      ST_DATA_STORE: begin
        // sub 0 primes ram, sub 1 latches, sub 2 writes
        ram_addr = RAM_DATA_BASE + cnt;
        dma_addr = buf_base + {8'h00, cnt};
        dma_data_out = crc_hold;
        if (sub == 2'h0) begin
          next_sub = 2'h1;
        end else if (sub == 2'h1) begin
          next_crc_hold = ram_rdata;
          next_sub = 2'h2;
          next_hold_pending = !other_dma_request;
        end else begin
          next_hold_pending = 1'b1;
          if (acc) begin
            dma_data_oe = 1'b1;
            dma_mem_write = 1'b1;
            next_hold_pending = 1'b0;
            next_cnt = cnt + 8'h01;
            next_sub = 2'h0;
            ram_addr = RAM_DATA_BASE + cnt + 8'h01;
            if (cnt == SECTOR_BYTES - 8'h01) begin
              next_status = STATUS_OK;
              next_state = ST_STATUS_PUT;
            end
          end
        end
      end
      ST_STATUS_PUT: begin
        next_hold_pending = !other_dma_request || hold_req;
        dma_addr = cs_base + {13'h0000, CS_STATUS};
        dma_data_out = status;
        if (acc) begin
          dma_data_oe = 1'b1;
          dma_mem_write = 1'b1;
          next_hold_pending = 1'b0;
          next_state = ST_CS_LOAD;
        end
      end
      ST_CS_LOAD: begin
        next_sub = 2'h0;
        next_cnt = 8'h00;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cmd_pending <= 1'b0;
      port_addr <= PORT_DEFAULT;
      strap_taken <= 1'b0;
      cs_base <= 16'h0000;
      buf_base <= 16'h0000;
      cur_track <= 8'h00;
      tgt_track <= 8'h00;
      tgt_sector <= 8'h00;
      cmd_code <= 8'h00;
      cnt <= 8'h00;
      sub <= 2'h0;
      crc <= CRC_PRESET;
      crc_hold <= 8'h00;
      status <= 8'h00;
      hold_pending <= 1'b0;
    end else begin
      state <= next_state;
      cmd_pending <= next_cmd_pending;
      port_addr <= next_port_addr;
      strap_taken <= next_strap_taken;
      cs_base <= next_cs_base;
      buf_base <= next_buf_base;
      cur_track <= next_cur_track;
      tgt_track <= next_tgt_track;
      tgt_sector <= next_tgt_sector;
      cmd_code <= next_cmd_code;
      cnt <= next_cnt;
      sub <= next_sub;
      crc <= next_crc;
      crc_hold <= next_crc_hold;
      status <= next_status;
      hold_pending <= next_hold_pending;
    end
  end
endmodule

// >>> tb/dcdma_ctrl_asserts.sv
// concurrent checks on the controller ports
`timescale 1ns/100ps
module dcdma_ctrl_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] port_strap,
  input wire logic host_out_strobe,
  input wire logic [7:0] host_io_addr,
  input wire logic host_ready,
  input wire logic hold_req,
  input wire logic host_hold_acknowledge,
  input wire logic host_t3,
  input wire logic host_drv_disable,
  input wire logic [15:0] dma_addr,
  input wire logic [7:0] dma_data_out,
  input wire logic dma_mem_read,
  input wire logic dma_mem_write,
  input wire logic dma_bus_oe,
  input wire logic priority_chain_out,
  input wire logic other_dma_request,
  input wire logic step_pulse,
  input wire logic disk_wr_valid,
  input wire logic disk_wr_gate,
  input wire logic byte_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ====================
  // named steps
  sequence s_port_hit;
    $past(host_out_strobe) && $past(host_io_addr) == $past(port_strap);
  endsequence
  sequence s_wr_slot;
    byte_tick && disk_wr_gate;
  endsequence
  // ====================
  // checks
  a_ready_one:
    assert property ($fell(host_ready) |=> host_ready) else $error("ready held low too long");
  a_ready_cause:
    assert property (!host_ready |-> s_port_hit) else $error("ready low without a port write");
  a_drv_grant:
    assert property (host_drv_disable |-> hold_req && host_hold_acknowledge) else $error("drivers off without grant");
  a_bus_owned:
    assert property (dma_mem_read || dma_mem_write |-> dma_bus_oe && host_drv_disable) else $error("access off bus");
  a_dma_t3:
    assert property (dma_mem_read || dma_mem_write |-> host_t3) else $error("dma byte outside t3");
  a_hold_wait:
    assert property ($rose(hold_req) |-> !$past(other_dma_request)) else $error("hold raised over other master");
  a_chain_block:
    assert property (hold_req |-> !priority_chain_out) else $error("priority passed while requesting");
  a_step_pulse:
    assert property (step_pulse |=> !step_pulse) else $error("step pulse too long");
  a_wr_slot:
    assert property (disk_wr_valid |-> s_wr_slot) else $error("disk byte off its slot");
  a_status_set:
    assert property (dma_mem_write && dma_addr == 16'h0001 |-> dma_data_out != 8'h00) else $error("zero status");
endmodule

bind dcdma_ctrl dcdma_ctrl_asserts u_chk (.clk(clk), .nrst(nrst), .port_strap(port_strap),
  .host_out_strobe(host_out_strobe), .host_io_addr(host_io_addr), .host_ready(host_ready), .hold_req(hold_req),
  .host_hold_acknowledge(host_hold_acknowledge), .host_t3(host_t3), .host_drv_disable(host_drv_disable),
  .dma_addr(dma_addr), .dma_data_out(dma_data_out), .dma_mem_read(dma_mem_read), .dma_mem_write(dma_mem_write),
  .dma_bus_oe(dma_bus_oe), .priority_chain_out(priority_chain_out), .other_dma_request(other_dma_request),
  .step_pulse(step_pulse), .disk_wr_valid(disk_wr_valid), .disk_wr_gate(disk_wr_gate), .byte_tick(byte_tick));

// >>> tb/dcdma_host_model.sv
// host memory and hold handshake model facing the dma channel
`timescale 1ns/100ps
module dcdma_host_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] ack_lag,
  input wire logic [7:0] cmd_data,
  input wire logic hold_req,
  input wire logic host_drv_disable,
  input wire logic [15:0] dma_addr,
  input wire logic [7:0] dma_data_out,
  input wire logic dma_mem_write,
  output logic host_hold_acknowledge,
  output logic host_t3,
  output logic [7:0] host_data_in
);
  logic [7:0] mem [256];
  logic [1:0] lag;
  // ====================
  // grant after a lag; t3 every other cycle while acknowledge is high
  always @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      host_hold_acknowledge <= 1'b0;
      host_t3 <= 1'b0;
      lag <= 2'h0;
    end else begin
      host_t3 <= host_hold_acknowledge & ~host_t3;
      lag <= (hold_req & ~host_hold_acknowledge) ? lag + 2'h1 : 2'h0;
      host_hold_acknowledge <= hold_req & (host_hold_acknowledge | lag == ack_lag);
    end
  end
  always @(posedge clk) begin
    if (dma_mem_write) begin
      mem[dma_addr[7:0]] <= dma_data_out;
    end
  end
  // released bus shows the bench pattern
  assign host_data_in = host_drv_disable ? mem[dma_addr[7:0]] : cmd_data;
endmodule

// >>> tb/dcdma_ctrl_test.sv
// self-checking bench for the diskette command dma controller
`timescale 1ns/100ps
module dcdma_ctrl_test;
  import dcdma_pkg::*;
  logic clk, nrst, host_out_strobe, host_hold_acknowledge, host_t3, byte_tick, id_mark_found, data_mark_found;
  logic disk_rd_valid, other_dma_request, host_ready, hold_req, host_drv_disable, dma_data_oe, dma_mem_read;
  logic dma_mem_write, dma_bus_oe, priority_chain_out, head_load, step_dir_in, step_pulse, disk_wr_valid, disk_wr_gate;
  logic [7:0] host_io_addr, host_data_in, cmd_data, disk_rd_data, dma_data_out, disk_wr_data, last_status;
  logic [15:0] dma_addr;
  logic [1:0] tick_cnt, ack_lag;
  int error_cnt, checks, cur_track, steps_up, steps_dn, tick_since, gap, holds;
  logic [7:0] wq[$];
  dcdma_ctrl dut (.clk(clk), .nrst(nrst), .port_strap(PORT_DEFAULT), .host_out_strobe(host_out_strobe),
    .host_io_addr(host_io_addr), .host_data_in(host_data_in), .host_ready(host_ready), .hold_req(hold_req),
    .host_hold_acknowledge(host_hold_acknowledge), .host_t3(host_t3), .host_drv_disable(host_drv_disable),
    .dma_addr(dma_addr), .dma_data_out(dma_data_out), .dma_data_oe(dma_data_oe), .dma_mem_read(dma_mem_read),
    .dma_mem_write(dma_mem_write), .dma_bus_oe(dma_bus_oe), .priority_chain_in(1'b1),
    .priority_chain_out(priority_chain_out), .other_dma_request(other_dma_request), .head_load(head_load),
    .step_dir_in(step_dir_in), .step_pulse(step_pulse), .disk_wr_data(disk_wr_data), .disk_wr_valid(disk_wr_valid),
    .disk_wr_gate(disk_wr_gate), .byte_tick(byte_tick), .id_mark_found(id_mark_found),
    .data_mark_found(data_mark_found), .disk_rd_data(disk_rd_data), .disk_rd_valid(disk_rd_valid),
    .last_status(last_status));
  dcdma_host_model host (.clk(clk), .nrst(nrst), .ack_lag(ack_lag), .cmd_data(cmd_data), .hold_req(hold_req),
    .host_drv_disable(host_drv_disable), .dma_addr(dma_addr), .dma_data_out(dma_data_out),
    .dma_mem_write(dma_mem_write), .host_hold_acknowledge(host_hold_acknowledge), .host_t3(host_t3),
    .host_data_in(host_data_in));
  // ====================
  // clock and drive monitor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) tick_cnt <= tick_cnt + 2'h1;
  assign byte_tick = tick_cnt == 2'h0;
  always @(posedge clk) begin
    if (step_pulse && step_dir_in) steps_up++;
    if (step_pulse && !step_dir_in) steps_dn++;
    if (step_pulse) cur_track = step_dir_in ? cur_track + 1 : cur_track - 1;
    if (disk_wr_valid && wq.size() == 0) gap = tick_since;
    if (disk_wr_valid) wq.push_back(disk_wr_data);
    if (disk_rd_valid) tick_since = 0;
    else if (byte_tick) tick_since++;
    if (hold_req && host_drv_disable && !$past(host_drv_disable)) holds++;
  end
  // ====================
  // shared tasks
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) r = r[15] ? {r[14:0], 1'b0} ^ CRC_POLY : {r[14:0], 1'b0};
    return r;
  endfunction
  task automatic send_cmd(input logic [7:0] addr, input logic [7:0] val, input logic exp_low);
    @(negedge clk);
    host_out_strobe <= 1'b1;
    host_io_addr <= addr;
    cmd_data <= val;
    @(negedge clk);
    host_out_strobe <= 1'b0;
    cmd_data <= ~val;
    check8("ready_low", {7'h0, ~exp_low}, {7'h0, host_ready});
    @(negedge clk);
    check8("ready_back", 8'h01, {7'h0, host_ready});
  endtask
  task automatic build(input logic [7:0] cmd, input logic [7:0] buf_lo);
    host.mem[0] = cmd;
    host.mem[1] = 8'h00;
    host.mem[2] = 8'h02;
    host.mem[3] = 8'h03;
    host.mem[4] = buf_lo;
    host.mem[5] = 8'h00;
  endtask
  task automatic disk_put(input logic [1:0] kind, input logic [7:0] d);
    @(negedge clk);
    while (tick_cnt != 2'h3) @(negedge clk);
    disk_rd_valid <= kind == 2'h0;
    id_mark_found <= kind == 2'h1;
    data_mark_found <= kind == 2'h2;
    disk_rd_data <= d;
    @(negedge clk);
    {disk_rd_valid, id_mark_found, data_mark_found} <= 3'h0;
    disk_rd_data <= ~d;
  endtask
  task automatic position(input int trk, input logic [7:0] sec);
    int n;
    logic [7:0] s;
    s = 8'h01;
    for (n = 0; n < 5000 && head_load !== 1'b1; n++) @(negedge clk);
    check8("head_load", 8'h01, {7'h0, head_load});
    for (n = 0; n < 80; n++) begin
      disk_put(2'h1, 8'h00);
      disk_put(2'h0, cur_track[7:0]);
      disk_put(2'h0, s);
      if (cur_track == trk && s == sec) break;
      s = (s == 8'h1a) ? 8'h01 : s + 8'h01;
      repeat (16) @(negedge clk);
    end
  endtask
  task automatic wait_status(input logic [7:0] exp);
    int n;
    for (n = 0; n < 20000 && host.mem[1] === 8'h00; n++) @(negedge clk);
    repeat (2) @(negedge clk);
    check8("status", exp, host.mem[1]);
    check8("last_status", exp, last_status);
  endtask
  // ====================
  // scenarios
  task automatic test_port;
    send_cmd(8'hfc, BYTE_CMD_EXEC, 1'b0);
    send_cmd(PORT_DEFAULT, 8'h05, 1'b1);
    repeat (20) @(negedge clk);
    check8("stray_hold", 8'h00, {7'h0, hold_req});
  endtask
  task automatic test_write;
    logic [15:0] crc;
    build(CMD_WRITE, 8'h40);
    for (int i = 0; i < 128; i++) host.mem[8'h40 + i] = 8'(i * 3 + 1);
    holds = 0;
    send_cmd(PORT_DEFAULT, BYTE_CMD_EXEC, 1'b1);
    position(2, 8'h03);
    check8("steps_up", 8'h02, 8'(steps_up));
    check8("steps_dn", 8'h00, 8'(steps_dn));
    wait_status(STATUS_OK);
    check8("holds", 8'h01, {7'h0, holds >= 129});
    check8("gap", 8'h01, {7'h0, gap >= 11 && gap <= 13});
    check8("wr_count", 8'd136, 8'(wq.size()));
    crc = crc_byte(CRC_PRESET, DATA_MARK);
    for (int i = 0; i < 5; i++) check8("sync", ZERO_BYTE, wq[i]);
    check8("mark", DATA_MARK, wq[5]);
    for (int i = 0; i < 128; i++) begin
      check8("wr_data", 8'(i * 3 + 1), wq[6 + i]);
      crc = crc_byte(crc, 8'(i * 3 + 1));
    end
    check8("crc_hi", crc[15:8], wq[134]);
    check8("crc_lo", crc[7:0], wq[135]);
  endtask
  task automatic test_read(input logic bad);
    logic [15:0] crc;
    logic seen;
    build(CMD_READ, 8'h80);
    for (int i = 0; i < 128; i++) host.mem[8'h80 + i] = 8'hee;
    other_dma_request <= 1'b1;
    send_cmd(PORT_DEFAULT, BYTE_CMD_EXEC, 1'b1);
    seen = 1'b0;
    repeat (40) @(negedge clk) seen = seen | hold_req;
    check8("hold_blocked", 8'h00, {7'h0, seen});
    other_dma_request <= 1'b0;
    position(2, 8'h03);
    disk_put(2'h2, DATA_MARK);
    crc = crc_byte(CRC_PRESET, DATA_MARK);
    for (int i = 0; i < 128; i++) begin
      disk_put(2'h0, 8'(i) ^ 8'h5a);
      crc = crc_byte(crc, 8'(i) ^ 8'h5a);
    end
    crc = crc ^ {15'h0, bad};
    disk_put(2'h0, crc[15:8]);
    disk_put(2'h0, crc[7:0]);
    wait_status(bad ? STATUS_CRC_ERR : STATUS_OK);
    for (int i = 0; i < 128; i++) check8("rd_buf", bad ? 8'hee : 8'(i) ^ 8'h5a, host.mem[8'h80 + i]);
  endtask
  task automatic test_badcmd;
    build(8'h07, 8'h40);
    send_cmd(PORT_DEFAULT, BYTE_CMD_EXEC, 1'b1);
    wait_status(STATUS_BAD_CMD);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ====================
  // main sequence and watchdog
  initial begin
    {nrst, host_out_strobe, id_mark_found, data_mark_found, disk_rd_valid, other_dma_request} = 6'h00;
    {host_io_addr, cmd_data, disk_rd_data} = 24'h0000_00;
    {tick_cnt, ack_lag} = 4'h1;
    {error_cnt, checks, cur_track, steps_up, steps_dn, tick_since, gap, holds} = '0;
    repeat (8) @(negedge clk);
    check8("rst_ready", 8'h01, {7'h0, host_ready});
    check8("rst_hold", 8'h00, {7'h0, hold_req});
    check8("rst_status", 8'h00, last_status);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    test_port;
    test_write;
    test_read(1'b0);
    test_read(1'b1);
    test_badcmd;
    tally_and_finish;
  end
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule
